// file: rtl/filt_pkg.sv
// Constants and types shared by the filter accelerator datapath files.
// Assumes a single clock domain; no bus registers are reached by software.
package filt_pkg;
    localparam int DATA_W = 24;
    localparam int ACC_W = 48;
    localparam int PAIRS = 64;
    localparam int ADDR_W = 6;
    localparam int CTRL_W = 18;
    localparam int RES_HI = 46;
    localparam int RES_LO = 23;
    localparam int SEG_TAPS = 16;
    localparam logic [23:0] POS_MAX = 24'h7fffff;
    localparam logic [23:0] NEG_MAX = 24'h800000;
    // Control word field positions
    localparam int F_ALU_LSB = 0;   // 3 bits
    localparam int F_ACLR_BIT = 3;  // 1 bit, clear accumulator before add
    localparam int F_MEN_BIT = 4;   // 1 bit, multiply-accumulate enable
    localparam int F_ADDR_LSB = 5;  // 6 bits, tap address
    localparam int F_WEN_BIT = 11;  // 1 bit, write result back into sample RAM
    localparam int F_OUT_BIT = 12;  // 1 bit, publish ALU result
    localparam int F_PARM_LSB = 13; // 5 bits, threshold shift amount
    typedef enum logic [2:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_CMP, ALU_THR, ALU_ABS, ALU_SQL, ALU_SAT
    } alu_op_t;
endpackage

// file: rtl/skid_buf.sv
// Two-entry valid/ready buffer for result words.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module skid_buf (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic i_valid,
    input wire logic [23:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [23:0] o_data,
    input wire logic i_ready
);
    logic [23:0] mem_q [2];
    logic [23:0] mem_d [2];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign o_ready = (cnt_q != 2'h2);
    assign o_valid = (cnt_q != 2'h0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = i_data;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mem_q[0] <= 24'h000000;
            mem_q[1] <= 24'h000000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    chk_data_holds: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        o_valid && !i_ready |=> o_valid && o_data == $past(o_data)) else $error("word moved");
endmodule

// file: rtl/filter_accelerator.sv
// Numeric datapath of the filter accelerator: MAC, ALU, sample and coefficient RAMs.
// Assumes a sequencer drives the control word each cycle and a bus target moves data.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Multiply two signed 24-bit values and accumulate, one per clock.
// - All data is 24 bits except the 48-bit accumulator.
// - MAC result to ALU is accumulator bits 46 down to 23.
// - Operands are fractions with binary point after the sign bit.
// - ALU offers add, subtract, compare, threshold, absolute, squelch, saturate.
// - An 18-bit control word of seven fields steers every cycle.
// - Sample and coefficient RAMs hold 64 data/coefficient pairs.
// - Pairs serve one 64-tap FIR or four 16-tap FIR/IIR filters.
module filter_accelerator (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [17:0] I_CTRL,
    input wire logic I_SMP_WE,
    input wire logic I_COEF_WE,
    input wire logic [5:0] I_WADDR,
    input wire logic [23:0] I_WDATA,
    input wire logic [23:0] I_ALU_B,
    input wire logic I_RES_RD,
    output logic O_RES_VALID,
    output logic [23:0] O_RES_DATA,
    output logic O_STALL,
    output logic O_CMP_FLAG
);
    logic [23:0] smp_ram [64];
    logic [23:0] coef_ram [64];
    logic [47:0] acc_q, acc_d;
    logic [23:0] alu_q, alu_d;
    logic flag_q, flag_d;
    logic out_q, out_d;
    logic [23:0] smp_rd, coef_rd, mac_res;
    logic [47:0] prod;
    filt_pkg::alu_op_t op;
    logic [5:0] taddr;
    logic [4:0] parm;
    logic buf_ready;

    // Field decode used by the ALU and RAM paths
    function automatic logic [5:0] tap_addr(input logic [17:0] w);
        tap_addr = w[filt_pkg::F_ADDR_LSB +: filt_pkg::ADDR_W];
    endfunction

    assign op = filt_pkg::alu_op_t'(I_CTRL[filt_pkg::F_ALU_LSB +: 3]);
    assign taddr = tap_addr(I_CTRL);
    assign parm = I_CTRL[filt_pkg::F_PARM_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////////
    // RAMs; a sample bus write takes priority over write-back, and a write-back in the same cycle is dropped
    always_ff @(posedge I_CLK) begin
        if (I_SMP_WE) begin
            smp_ram[I_WADDR] <= I_WDATA;
        end else if (I_CTRL[filt_pkg::F_WEN_BIT]) begin
            smp_ram[taddr] <= alu_q;
        end
        if (I_COEF_WE) begin
            coef_ram[I_WADDR] <= I_WDATA;
        end
    end
    assign smp_rd = smp_ram[taddr];
    assign coef_rd = coef_ram[taddr];

    ////////////////////////////////////////////////////////////////////////////
    // MAC: signed fractional product; taking bits 46:23 drops the duplicate sign bit
    assign prod = $signed(smp_rd) * $signed(coef_rd);
    assign mac_res = acc_q[filt_pkg::RES_HI:filt_pkg::RES_LO];

    always_comb begin
        acc_d = acc_q;
        if (I_CTRL[filt_pkg::F_MEN_BIT]) begin
            if (I_CTRL[filt_pkg::F_ACLR_BIT]) begin
                acc_d = prod;
            end else begin
                acc_d = acc_q + prod;
            end
        end else if (I_CTRL[filt_pkg::F_ACLR_BIT]) begin
            acc_d = 48'h000000000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ALU on 24-bit values
    always_comb begin
        logic [24:0] sum;
        logic [23:0] lim;
        sum = 25'h0000000;
        lim = filt_pkg::POS_MAX >> parm;
        alu_d = alu_q;
        flag_d = flag_q;
        case (op)
            filt_pkg::ALU_PASS: alu_d = mac_res;
            filt_pkg::ALU_ADD: begin
                sum = {mac_res[23], mac_res} + {I_ALU_B[23], I_ALU_B};
                alu_d = (sum[24] != sum[23]) ?
                    (sum[24] ? filt_pkg::NEG_MAX : filt_pkg::POS_MAX) : sum[23:0];
            end
            filt_pkg::ALU_SUB: begin
                sum = {mac_res[23], mac_res} - {I_ALU_B[23], I_ALU_B};
                alu_d = (sum[24] != sum[23]) ?
                    (sum[24] ? filt_pkg::NEG_MAX : filt_pkg::POS_MAX) : sum[23:0];
            end
            filt_pkg::ALU_CMP: flag_d = ($signed(mac_res) > $signed(I_ALU_B));
            filt_pkg::ALU_THR: begin
                flag_d = ($signed(mac_res) > $signed(lim)) || ($signed(mac_res) < -$signed(lim));
                alu_d = flag_d ? mac_res : 24'h000000;
            end
            filt_pkg::ALU_ABS: alu_d = mac_res[23] ?
                ((mac_res == filt_pkg::NEG_MAX) ? filt_pkg::POS_MAX : -mac_res) : mac_res;
            filt_pkg::ALU_SQL: alu_d = ((mac_res[23] ? -mac_res : mac_res) < I_ALU_B) ?
                24'h000000 : mac_res;
            filt_pkg::ALU_SAT: alu_d = (acc_q[47] != acc_q[46]) ?
                (acc_q[47] ? filt_pkg::NEG_MAX : filt_pkg::POS_MAX) : mac_res;
            default: alu_d = alu_q;
        endcase
        out_d = I_CTRL[filt_pkg::F_OUT_BIT] && buf_ready;
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            acc_q <= 48'h000000000000;
            alu_q <= 24'h000000;
            flag_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            alu_q <= alu_d;
            flag_q <= flag_d;
            out_q <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result path to the bus target; stall tells the sequencer to hold
    skid_buf u_buf (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .i_valid(out_q),
        .i_data(alu_q),
        .o_ready(buf_ready),
        .o_valid(O_RES_VALID),
        .o_data(O_RES_DATA),
        .i_ready(I_RES_RD)
    );
    assign O_STALL = !buf_ready;
    assign O_CMP_FLAG = flag_q;

    chk_mac_step: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_CTRL[filt_pkg::F_MEN_BIT] && !I_CTRL[filt_pkg::F_ACLR_BIT]
        |=> acc_q == $past(acc_q) + $past(prod)) else $error("mac step wrong");
    chk_pass_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_PASS |=> alu_q == $past(acc_q[46:23])) else $error("pass wrong");
    chk_abs_pos: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_ABS |=> !alu_q[23]) else $error("abs negative");
    chk_acc_clear: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !I_CTRL[filt_pkg::F_MEN_BIT] && I_CTRL[filt_pkg::F_ACLR_BIT] |=> acc_q == 48'h0)
        else $error("clear failed");
    chk_out_push: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_CTRL[filt_pkg::F_OUT_BIT] && buf_ready |=> ##1 O_RES_VALID) else $error("no result");
    chk_sat_bound: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_SAT && acc_q[47] && !acc_q[46] |=> alu_q == filt_pkg::NEG_MAX)
        else $error("sat wrong");
    chk_cmp_flag: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_CMP |=> O_CMP_FLAG == ($signed($past(mac_res)) > $signed($past(I_ALU_B))))
        else $error("cmp wrong");
    chk_stall_full: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_STALL |-> O_RES_VALID) else $error("stall while empty");

    ////////////////////////////////////////////////////////////////////////////
    // Accumulator hold, ALU corners, RAM writes and publish refusal

    chk_acc_load: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_CTRL[filt_pkg::F_MEN_BIT] && I_CTRL[filt_pkg::F_ACLR_BIT]
        |=> acc_q == $past(prod)) else $error("acc load wrong");

    chk_acc_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !I_CTRL[filt_pkg::F_MEN_BIT] && !I_CTRL[filt_pkg::F_ACLR_BIT]
        |=> acc_q == $past(acc_q)) else $error("acc not held");

    chk_sql_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_SQL && !mac_res[23] && (mac_res < I_ALU_B)
        |=> alu_q == 24'h000000) else $error("squelch kept small value");

    chk_sql_keep: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_SQL && !mac_res[23] && (mac_res >= I_ALU_B)
        |=> alu_q == $past(mac_res)) else $error("squelch dropped large value");

    chk_thr_flag: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_THR
        |=> (alu_q != 24'h000000) == O_CMP_FLAG) else $error("threshold flag wrong");

    chk_add_pos: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_ADD && !mac_res[23] && !I_ALU_B[23]
        |=> !alu_q[23]) else $error("add wrapped");

    chk_sub_neg: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_SUB && mac_res[23] && !I_ALU_B[23]
        |=> alu_q[23]) else $error("sub wrapped");

    chk_sat_pos: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        op == filt_pkg::ALU_SAT && !acc_q[47] && acc_q[46]
        |=> alu_q == filt_pkg::POS_MAX) else $error("sat high wrong");

    chk_smp_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_SMP_WE
        |=> smp_ram[$past(I_WADDR)] == $past(I_WDATA)) else $error("sample write lost");

    chk_coef_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_COEF_WE
        |=> coef_ram[$past(I_WADDR)] == $past(I_WDATA)) else $error("coef write lost");

    chk_wback: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_CTRL[filt_pkg::F_WEN_BIT] && !I_SMP_WE
        |=> smp_ram[$past(taddr)] == $past(alu_q)) else $error("write-back lost");

    chk_stall_drop: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_STALL
        |=> !out_q) else $error("publish taken while full");
endmodule

// file: tb/result_reader.sv
// Model of the bus-side consumer that pulls results out of the filter accelerator.
// Assumes one clock; it stalls at random and holds ready low while told to stall.
`timescale 1ns/1ps
module result_reader (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic i_valid,
    input wire logic [23:0] i_data,
    input wire logic i_stall,
    output logic o_ready
);
    logic [23:0] got[$];
    ////////////////////////////////////////////////////////////////////////////
    // Takes a word only on an edge where valid and ready are both high
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            o_ready <= 1'b0;
        end else begin
            if (i_valid && o_ready) begin
                got.push_back(i_data);
            end
            // Slow and prompt answers alike, so the buffer sees both
            o_ready <= !i_stall && ($urandom % 4 != 0);
        end
    end
endmodule

// file: tb/fir_iir_filter_datapath_tb.sv
// Self-checking bench for the filter accelerator datapath.
// Assumes the result reader model on the output side and one 100 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module fir_iir_filter_datapath_tb;
    logic clk = 0, rst_n = 0, smp_we = 0, coef_we = 0, stall_en = 0, res_rd, res_valid;
    logic stall, cmp_flag;
    logic [17:0] ctrl = '0;
    logic [5:0] waddr = '0;
    logic [23:0] wdata = '0, alu_b = '0, res_data;
    logic [23:0] exp_q[$];
    logic [4:0] shift = '0;
    int num_errors = 0, comparisons = 0;
    filter_accelerator DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_CTRL(ctrl), .I_SMP_WE(smp_we),
        .I_COEF_WE(coef_we), .I_WADDR(waddr), .I_WDATA(wdata), .I_ALU_B(alu_b),
        .I_RES_RD(res_rd), .O_RES_VALID(res_valid), .O_RES_DATA(res_data), .O_STALL(stall),
        .O_CMP_FLAG(cmp_flag));
    result_reader rd (.I_CLK(clk), .I_RST_N(rst_n), .i_valid(res_valid), .i_data(res_data),
        .i_stall(stall_en), .o_ready(res_rd));
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [17:0] cw(logic [2:0] op, logic clr, logic men, logic [5:0] a,
            logic pub);
        return {shift, pub, 1'b0, a, men, clr, op};
    endfunction
    // Add and subtract clamp at the 24-bit limits instead of wrapping
    function automatic logic [23:0] alu_ref(logic [2:0] op, logic signed [47:0] a,
            logic signed [23:0] b);
        logic signed [23:0] x, lim;
        logic [23:0] m;
        logic signed [24:0] s;
        x = a[46:23];
        m = x[23] ? -x : x;
        lim = filt_pkg::POS_MAX >> shift;
        case (op)
            filt_pkg::ALU_ADD: s = x + b;
            filt_pkg::ALU_SUB: s = x - b;
            filt_pkg::ALU_ABS: s = (x < 0) ? -x : x;
            filt_pkg::ALU_SQL: s = (m < $unsigned(b)) ? 25'sh0 : x;
            filt_pkg::ALU_THR: s = ((x > lim) || (x < -lim)) ? x : 25'sh0;
            filt_pkg::ALU_SAT: begin
                if (a[47] != a[46]) return a[47] ? filt_pkg::NEG_MAX : filt_pkg::POS_MAX;
                s = x;
            end
            default: s = x;
        endcase
        if (s > $signed({1'b0, filt_pkg::POS_MAX})) return filt_pkg::POS_MAX;
        if (s < $signed({1'b1, filt_pkg::NEG_MAX})) return filt_pkg::NEG_MAX;
        return s[23:0];
    endfunction
    function automatic logic flag_ref(logic [2:0] op, logic signed [47:0] a,
            logic signed [23:0] b);
        logic signed [23:0] x, lim;
        x = a[46:23];
        lim = filt_pkg::POS_MAX >> shift;
        return (op == filt_pkg::ALU_CMP) ? (x > b) : ((x > lim) || (x < -lim));
    endfunction
    task automatic step(logic [17:0] c);
        ctrl = c;
        @(posedge clk) #1;
    endtask
    // Loads n pairs, runs the taps back to back, then publishes one result unless op is ALU_CMP
    task automatic calc(logic [2:0] op, int n, bit corner, bit keep);
        logic [5:0] ad[4];
        logic signed [23:0] sv[4], cv[4];
        logic signed [47:0] acc;
        acc = '0;
        ad[0] = 6'($urandom);
        alu_b = 24'($urandom);
        shift = 5'($urandom);
        for (int k = 0; k < n; k++) begin
            ad[k] = ad[0] + 6'(k);
            sv[k] = corner ? filt_pkg::NEG_MAX : 24'($urandom);
            cv[k] = corner ? filt_pkg::POS_MAX : 24'($urandom);
            acc += sv[k] * cv[k];
            waddr = ad[k];
            wdata = sv[k];
            smp_we = 1;
            @(posedge clk) #1;
            smp_we = 0;
            coef_we = 1;
            wdata = cv[k];
            @(posedge clk) #1;
            coef_we = 0;
        end
        for (int k = 0; k < n; k++) step(cw(op, k == 0, 1'b1, ad[k], 1'b0));
        step(cw(op, 1'b0, 1'b0, 6'h00, 1'b0));
        step(cw(op, 1'b0, 1'b0, 6'h00, 1'b0));
        step(cw(op, 1'b0, 1'b0, 6'h00, op != filt_pkg::ALU_CMP));
        step(cw(op, 1'b0, 1'b0, 6'h00, 1'b0));
        if (keep && op != filt_pkg::ALU_CMP) exp_q.push_back(alu_ref(op, acc, alu_b));
        if (op == filt_pkg::ALU_CMP || op == filt_pkg::ALU_THR) begin
            `CHK(cmp_flag, flag_ref(op, acc, alu_b))
        end
    endtask
    task automatic drain();
        for (int i = 0; i < 400 && rd.got.size() < exp_q.size(); i++) @(posedge clk) #1;
        repeat (4) @(posedge clk) #1;
        `CHK(rd.got.size(), exp_q.size())
        for (int i = 0; i < exp_q.size() && i < rd.got.size(); i++) begin
            `CHK(rd.got[i], exp_q[i])
        end
        `CHK(res_valid, 1'b0)
        rd.got.delete();
        exp_q.delete();
    endtask
    task automatic test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        test_done();
    end
    initial begin
        logic [2:0] ops[8];
        ops = '{filt_pkg::ALU_PASS, filt_pkg::ALU_ADD, filt_pkg::ALU_SUB, filt_pkg::ALU_ABS,
            filt_pkg::ALU_SQL, filt_pkg::ALU_SAT, filt_pkg::ALU_THR, filt_pkg::ALU_CMP};
        void'($urandom(41));
        repeat (12) @(posedge clk);
        #1 rst_n = 1;
        `CHK(res_valid, 1'b0)
        calc(filt_pkg::ALU_PASS, 1, 1, 1);
        calc(filt_pkg::ALU_SAT, 2, 1, 1);
        for (int i = 0; i < 16; i++) calc(ops[i % 8], 1 + i % 4, 0, 1);
        drain();
        // Reader stalls: two words fit, the third publish must be ignored
        stall_en = 1;
        for (int i = 0; i < 3; i++) calc(filt_pkg::ALU_ADD, 2, 0, i < 2);
        `CHK(stall, 1'b1)
        `CHK(res_valid, 1'b1)
        stall_en = 0;
        drain();
        test_done();
    end
endmodule
